/* File: sim/tzc_pin_model.sv */
// Model of the external count clock and interrupt pins
`timescale 1ns/1ns
module tzc_pin_model
(
  input  wire clk_sys,
  output reg  ext_count_clock_pin,
  output reg  ext_interrupt_pin
);
  // Pins idle low; the model can hold a level long or short to pace edges
  initial
  begin
    ext_count_clock_pin = 1'b0;
    ext_interrupt_pin = 1'b0;
  end
  task drive(input sel, input v, input integer hold);
  begin
    @(posedge clk_sys);
    if (sel)
      ext_interrupt_pin <= v;
    else
      ext_count_clock_pin <= v;
    repeat (hold) @(posedge clk_sys);
  end
  endtask
endmodule

/* File: sim/tzc_timer_zero_asserts.sv */
// Checker of bus answers, read-back and reset behaviour of the timer zero block
`timescale 1ns/1ns
module tzc_timer_zero_chk
(
  input wire        clk_sys,
  input wire        rst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        irq
);
  // ----------------------------------------------------------------
  // Helper: address of the read under way
  // ----------------------------------------------------------------
  reg [31:0] ra_q;
  always @(posedge clk_sys)
    if (s_axi_arvalid && s_axi_arready)
      ra_q <= s_axi_araddr;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  ctrl_bit0_a: assert property (s_axi_rvalid && ra_q == 32'h0000_0014 |-> !s_axi_rdata[0])
    else $error("control bit 0 reads one");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  rst_clear_a: assert property (disable iff (1'b0) rst |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs not cleared by reset");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && ra_q == 32'h0000_0014);
  cover property ($rose(irq));
endmodule
bind tzc_timer_zero tzc_timer_zero_chk u_chk (.*);

/* File: sim/tzc_timer_zero_bench.sv */
// Self-checking bench for the timer zero block
`timescale 1ns/1ns
module tzc_timer_zero_bench;
  localparam [31:0] A_CTRL = 32'h0000_0014, A_CLO = 32'h0000_0018, A_ST = 32'h0000_0020;
  localparam [31:0] A_MSK = 32'h0000_0024;
  reg clk_sys = 1'b0, rst = 1'b1;
  reg [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire ext_count_clock_pin, ext_interrupt_pin;
  integer error_cnt = 0, compares = 0, cyc = 0, i, t0, k;
  reg [7:0] d, c0;
  reg [1:0] r;
  reg [15:0] rows [0:3];
  tzc_timer_zero DUT (.*, .s_axi_wstrb(4'hF));
  tzc_pin_model pins (.*);
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input [31:0] s, input [31:0] e);
  begin
    compares = compares + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  task wr(input [31:0] a, input [7:0] v);
  begin
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  end
  endtask
  task rd(input [31:0] a, output [7:0] v);
  begin
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 0;
  end
  endtask
  // Reads are equally long, so the gap between two samples is exact up to one tick
  task psc(input [7:0] ctl, input integer n, input integer w);
  begin
    wr(A_CTRL, ctl);
    rd(A_CLO, c0);
    t0 = cyc;
    repeat (w) @(posedge clk_sys);
    rd(A_CLO, d);
    k = ((d - c0) & 255) << n;
    t0 = cyc - t0;
    chk("prescale", k > t0 - (1 << n) && k < t0 + (1 << n), 1);
  end
  endtask
  task cpin(input v, input integer inc);
  begin
    rd(A_CLO, c0);
    pins.drive(0, v, 3);
    rd(A_CLO, d);
    chk("count step", (d - c0) & 255, inc);
  end
  endtask
  task ipin(input v, input [7:0] st);
  begin
    pins.drive(1, v, 3);
    rd(A_ST, d);
    chk("int status", d, st);
  end
  endtask
  task end_of_test;
  begin
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rows[0] = 16'hFFFE;
    rows[1] = 16'h5554;
    rows[2] = 16'hA1A0;
    rows[3] = 16'h0000;
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    rd(A_CTRL, d);
    chk("ctrl reset", d, 0);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(A_CTRL, rows[i][15:8]);
      rd(A_CTRL, d);
      chk("ctrl", d, rows[i][7:0]);
    end
    rd(32'h0000_0040, d);
    chk("unmapped", r, 2'h2);
    psc(8'h20, 0, 60);
    psc(8'h66, 3, 200);
    psc(8'h2E, 7, 1000);
    psc(8'h30, 8, 1000);
    psc(8'h3E, 8, 1000);
    wr(A_CTRL, 8'h40);
    cpin(1, 1);
    cpin(0, 0);
    wr(A_CTRL, 8'h00);
    cpin(1, 0);
    cpin(0, 1);
    rd(A_ST, d);
    chk("clock pin flag", d[1], 1);
    wr(A_CTRL, 8'h20);
    wr(32'h0000_001C, 8'hFF);
    wr(A_CLO, 8'hF0);
    repeat (20) @(posedge clk_sys);
    rd(A_ST, d);
    chk("overflow flag", d[2], 1);
    wr(A_ST, 8'h07);
    wr(A_MSK, 8'h01);
    wr(A_CTRL, 8'h80);
    ipin(1, 8'h01);
    chk("irq", irq, 1);
    wr(A_ST, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("irq clear", irq, 0);
    ipin(0, 8'h00);
    wr(A_CTRL, 8'h00);
    ipin(1, 8'h00);
    ipin(0, 8'h01);
    wr(A_MSK, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("irq masked", irq, 0);
    end_of_test;
  end
  initial
  begin
    #(50 * 20000);
    error_cnt = error_cnt + 1;
    end_of_test;
  end
endmodule

/* File: verilog/tzc_regs.vh */
// Register map, field positions, reset values and bus answers for the timer zero block
// How it works
// - Control bit 7 picks the interrupt pin edge that sets its flag: 1 rising, 0 falling.
// - With the external source chosen, bit 6 picks the counting edge: 1 rising, 0 falling.
// - With the pin source chosen, each chosen edge of the external clock pin ticks the prescaler and sets the pin flag.
// - Bit 5 picks the clock source: 1 the internal instruction-cycle clock, 0 the pin.
// - Bits 4 to 1 give prescale 1:1 to 1:128 doubling per code, and 1:256 for codes 1xxx.
// - Bit 0 is not implemented, ignores writes and reads as zero.
// - All implemented control bits are read/write and clear to zero at reset.
// - The timer is a 16-bit count in two bytes behind an 8-bit prescaler, 24 bits in all.
`ifndef TZC_REGS_VH
`define TZC_REGS_VH

// ----------------------------------------------------------------
// Register indices; the bus byte address is four times the index
// ----------------------------------------------------------------
`define TZC_IDX_CTRL      8'h05
`define TZC_IDX_CNT_LO    8'h06
`define TZC_IDX_CNT_HI    8'h07
`define TZC_IDX_IRQ_STAT  8'h08
`define TZC_IDX_IRQ_MASK  8'h09
`define TZC_ADDR_W        8

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define TZC_CTRL_INT_EDGE 7
`define TZC_CTRL_CLK_EDGE 6
`define TZC_CTRL_SRC      5
`define TZC_CTRL_PS_HI    4
`define TZC_CTRL_PS_LO    1
`define TZC_CTRL_WMASK    8'hFE

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define TZC_IRQ_INT_PIN   0
`define TZC_IRQ_CLK_PIN   1
`define TZC_IRQ_OVF       2
`define TZC_IRQ_W         3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TZC_CTRL_RST      8'h00
`define TZC_CNT_RST       16'h0000
`define TZC_IRQ_RST       3'h0

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define TZC_RESP_OKAY     2'h0
`define TZC_RESP_SLVERR   2'h2

`endif

/* File: verilog/tzc_timer_zero.v */
// Timer zero with clock/edge/prescale control, pin interrupts and AXI4-Lite slave
`timescale 1ns/1ns
`include "tzc_regs.vh"

module tzc_timer_zero
(
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        ext_count_clock_pin,
  input  wire        ext_interrupt_pin,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]            timer_zero_ctrl_status_q;
  reg  [15:0]           timer_zero_count_q;
  reg  [7:0]            prescale_cnt_q;
  wire [`TZC_IRQ_W-1:0] irq_stat_q;
  reg  [`TZC_IRQ_W-1:0] irq_mask_q;
  reg                   aw_hold_q;
  reg  [31:0]           awaddr_q;
  reg                   w_hold_q;
  reg  [31:0]           wdata_q;
  reg  [3:0]            wstrb_q;

  wire                  ext_int_edge_select;
  wire                  ext_clock_edge_select;
  wire                  count_source_select;
  wire [3:0]            prescale_select;

  assign ext_int_edge_select   = timer_zero_ctrl_status_q[`TZC_CTRL_INT_EDGE];
  assign ext_clock_edge_select = timer_zero_ctrl_status_q[`TZC_CTRL_CLK_EDGE];
  assign count_source_select   = timer_zero_ctrl_status_q[`TZC_CTRL_SRC];
  assign prescale_select       = timer_zero_ctrl_status_q[`TZC_CTRL_PS_HI:`TZC_CTRL_PS_LO];

  // ----------------------------------------------------------------
  // Edge detection on the pins
  // ----------------------------------------------------------------
  // Pins are taken as synchronous; one stage of history gives the edge.
  // History resets to the idle low level, so reset itself makes no edge.
  wire [1:0] pin_now;
  wire [1:0] pin_sel;
  wire [1:0] pin_edge;

  assign pin_now = {ext_interrupt_pin, ext_count_clock_pin};
  assign pin_sel = {ext_int_edge_select, ext_clock_edge_select};

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_pin
      reg  hist_q;
      wire rise;
      wire fall;
      always @(posedge clk_sys)
      begin
        if (rst)
          hist_q <= 1'b0;
        else
          hist_q <= pin_now[p];
      end
      assign rise        = pin_now[p] & ~hist_q;
      assign fall        = ~pin_now[p] & hist_q;
      assign pin_edge[p] = pin_sel[p] ? rise : fall;
    end
  endgenerate

  wire clk_edge = pin_edge[0];
  wire int_edge = pin_edge[1];

  // Internal source ticks every cycle; edge select then plays no part
  wire count_tick = count_source_select ? 1'b1 : clk_edge;

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  reg [7:0] ps_limit;
  always @*
  begin
    case (prescale_select)
      4'h0:    ps_limit = 8'h00;
      4'h1:    ps_limit = 8'h01;
      4'h2:    ps_limit = 8'h03;
      4'h3:    ps_limit = 8'h07;
      4'h4:    ps_limit = 8'h0F;
      4'h5:    ps_limit = 8'h1F;
      4'h6:    ps_limit = 8'h3F;
      4'h7:    ps_limit = 8'h7F;
      default: ps_limit = 8'hFF;
    endcase
  end

  // A ratio cut below the running prescale count wraps at once, not after 256 ticks
  wire ps_wrap  = count_tick && (prescale_cnt_q >= ps_limit);
  wire cnt_ovf  = ps_wrap && (timer_zero_count_q == 16'hFFFF);

  // ----------------------------------------------------------------
  // Bus write path
  // ----------------------------------------------------------------
  wire        aw_ok  = aw_hold_q | s_axi_awvalid;
  wire        w_ok   = w_hold_q | s_axi_wvalid;
  wire [31:0] wa     = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd     = w_hold_q ? wdata_q : s_axi_wdata;
  wire [3:0]  ws     = w_hold_q ? wstrb_q : s_axi_wstrb;
  wire        do_wr  = aw_ok && w_ok && !s_axi_bvalid;
  wire [7:0]  widx   = wa[`TZC_ADDR_W+1:2];
  wire        wr_en  = do_wr && ws[0] && (wa[1:0] == 2'b00);
  wire        wr_ctl = wr_en && (widx == `TZC_IDX_CTRL);
  wire        wr_lo  = wr_en && (widx == `TZC_IDX_CNT_LO);
  wire        wr_hi  = wr_en && (widx == `TZC_IDX_CNT_HI);
  wire        wr_st  = wr_en && (widx == `TZC_IDX_IRQ_STAT);
  wire        wr_mk  = wr_en && (widx == `TZC_IDX_IRQ_MASK);
  wire        w_map  = (widx >= `TZC_IDX_CTRL) && (widx <= `TZC_IDX_IRQ_MASK)
                       && (wa[31:`TZC_ADDR_W+2] == 22'h00_0000);

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TZC_RESP_OKAY;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 32'h0000_0000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end
    else
    begin
      // Ready pulses one cycle on each accepted beat
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_hold_q && !s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_hold_q && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_map ? `TZC_RESP_OKAY : `TZC_RESP_SLVERR;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register updates only happen once both beats are held
  wire commit = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Bit 0 is cleared by TZC_CTRL_WMASK on every write, so writes to it are dropped here
  always @(posedge clk_sys)
  begin
    if (rst)
      timer_zero_ctrl_status_q <= `TZC_CTRL_RST;
    else if (commit && wr_ctl)
      timer_zero_ctrl_status_q <= wd[7:0] & `TZC_CTRL_WMASK;
  end

  // ----------------------------------------------------------------
  // Interrupt mask and output
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
      irq_mask_q <= `TZC_IRQ_RST;
    else if (commit && wr_mk)
      irq_mask_q <= wd[`TZC_IRQ_W-1:0];
  end

  // Registered so the pin never glitches; costs one cycle of latency
  always @(posedge clk_sys)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Prescaler restarts when software reloads the count
  always @(posedge clk_sys)
  begin
    if (rst)
      prescale_cnt_q <= 8'h00;
    else if (commit && (wr_lo || wr_hi))
      prescale_cnt_q <= 8'h00;
    else if (count_tick)
      prescale_cnt_q <= ps_wrap ? 8'h00 : prescale_cnt_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A byte write wins over a tick in the same cycle; that tick is lost
  always @(posedge clk_sys)
  begin
    if (rst)
      timer_zero_count_q <= `TZC_CNT_RST;
    else if (commit && wr_lo)
      timer_zero_count_q[7:0] <= wd[7:0];
    else if (commit && wr_hi)
      timer_zero_count_q[15:8] <= wd[7:0];
    else if (ps_wrap)
      timer_zero_count_q <= timer_zero_count_q + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Interrupt status, one sticky bit per event
  // ----------------------------------------------------------------
  wire [`TZC_IRQ_W-1:0] irq_event;
  wire [`TZC_IRQ_W-1:0] irq_clear;

  assign irq_event[`TZC_IRQ_INT_PIN] = int_edge;
  assign irq_event[`TZC_IRQ_CLK_PIN] = clk_edge & ~count_source_select;
  assign irq_event[`TZC_IRQ_OVF]     = cnt_ovf;
  assign irq_clear = (commit && wr_st) ? wd[`TZC_IRQ_W-1:0] : 3'h0;

  genvar b;
  generate
    for (b = 0; b < `TZC_IRQ_W; b = b + 1)
    begin : g_stat
      reg stat_q;
      // Set wins over a write-one clear in the same cycle
      always @(posedge clk_sys)
      begin
        if (rst)
          stat_q <= 1'b0;
        else if (irq_event[b])
          stat_q <= 1'b1;
        else if (irq_clear[b])
          stat_q <= 1'b0;
      end
      assign irq_stat_q[b] = stat_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus read path
  // ----------------------------------------------------------------
  wire [7:0] ridx = s_axi_araddr[`TZC_ADDR_W+1:2];
  wire       r_hi_ok = (s_axi_araddr[31:`TZC_ADDR_W+2] == 22'h00_0000);
  reg  [31:0] rd_val;
  reg         rd_map;
  always @*
  begin
    rd_map = r_hi_ok;
    case (ridx)
      `TZC_IDX_CTRL:     rd_val = {24'h00_0000, timer_zero_ctrl_status_q};
      `TZC_IDX_CNT_LO:   rd_val = {24'h00_0000, timer_zero_count_q[7:0]};
      `TZC_IDX_CNT_HI:   rd_val = {24'h00_0000, timer_zero_count_q[15:8]};
      `TZC_IDX_IRQ_STAT: rd_val = {29'h0000_0000, irq_stat_q};
      `TZC_IDX_IRQ_MASK: rd_val = {29'h0000_0000, irq_mask_q};
      default:
      begin
        rd_val = 32'h0000_0000;
        rd_map = 1'b0;
      end
    endcase
  end

  // One-hot read sequence: wait for an address, take it, answer
  localparam [2:0] RD_IDLE   = 3'b001;
  localparam [2:0] RD_TAKE   = 3'b010;
  localparam [2:0] RD_ANSWER = 3'b100;

  reg [2:0] rd_state_q;
  reg [2:0] rd_state_d;

  always @*
  begin
    rd_state_d = rd_state_q;
    case (rd_state_q)
      RD_IDLE:
        if (s_axi_arvalid)
          rd_state_d = RD_TAKE;
      RD_TAKE:
        rd_state_d = s_axi_arvalid ? RD_ANSWER : RD_IDLE;
      RD_ANSWER:
        if (s_axi_rready)
          rd_state_d = RD_IDLE;
      default:
        rd_state_d = RD_IDLE;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      rd_state_q    <= RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TZC_RESP_OKAY;
    end
    else
    begin
      rd_state_q    <= rd_state_d;
      // Ready and valid follow the next state so both come from flops
      s_axi_arready <= (rd_state_d == RD_TAKE);
      s_axi_rvalid  <= (rd_state_d == RD_ANSWER);
      if ((rd_state_q == RD_TAKE) && s_axi_arvalid)
      begin
        s_axi_rdata <= rd_map ? rd_val : 32'h0000_0000;
        s_axi_rresp <= rd_map ? `TZC_RESP_OKAY : `TZC_RESP_SLVERR;
      end
    end
  end

endmodule
